// ---- logic/wdg_pkg.sv ----
// package of register map, field positions and constants for the watchdog block
`default_nettype none
package wdg_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] WDG_ADDR_RST_CAUSE = 8'h00; // reset_cause_status
  localparam logic [7:0] WDG_ADDR_CONTROL   = 8'h04; // watchdog_control

  // ****************************************************************
  // reset_cause_status fields
  // ****************************************************************
  localparam int WDG_BIT_SCAN = 4; // scan_chain_reset_flag
  localparam int WDG_BIT_WDOG = 3; // watchdog_reset_flag
  localparam int WDG_BIT_DIP  = 2; // supply_dip_reset_flag
  localparam int WDG_BIT_PIN  = 1; // pin_reset_flag
  localparam int WDG_BIT_POR  = 0; // power_on_reset_flag
  localparam logic [7:0] WDG_CAUSE_RST_VAL = 8'h01; // only the power-on flag
  localparam logic [7:0] WDG_CAUSE_FULL    = 8'h1F; // flags present normally
  localparam logic [7:0] WDG_CAUSE_LEGACY  = 8'h03; // flags kept in legacy mode

  // ****************************************************************
  // watchdog_control fields
  // ****************************************************************
  localparam int WDG_BIT_UNLOCK = 4; // watchdog_change_unlock
  localparam int WDG_BIT_EN     = 3; // watchdog_enable
  localparam int WDG_PS_HI      = 2; // timeout_prescale_select msb
  localparam int WDG_PS_W       = 3; // timeout_prescale_select width
  localparam logic [2:0] WDG_RSVD_ZERO = 3'h0; // bits 7:5
  localparam logic [2:0] WDG_PS_RST    = 3'h0; // shortest time-out

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [2:0] WDG_UNLOCK_CYCLES = 3'h4; // unlock window, clk cycles
  localparam int WDG_TIMEOUT_BASE = 16384; // oscillator cycles at select 000

  // safety level, one-hot
  typedef enum logic [2:0] {
    WDG_LVL0 = 3'b001,
    WDG_LVL1 = 3'b010,
    WDG_LVL2 = 3'b100
  } wdg_level_type;
endpackage
`default_nettype wire

// ---- logic/wdg_top.sv ----
// watchdog control, timed unlock, prescaled time-out and reset-cause flags
//
// Function
// [R1] level 1: starts off, enabling is free
// [R2] unlock write sets change-unlock and enable together; level 0 opens the window on change-unlock alone
// [R3] level 1: new settings accepted inside window
// [R4] level 2: always running, enable reads one
// [R5] level 2: prescaler change by timed sequence
// [R6] level 2: watchdog can never be disabled
// [R7] scan-chain reset sets bit 4
// [R8] watchdog reset sets bit 3
// [R9] supply-dip reset sets bit 2
// [R10] pin reset sets bit 1
// [R11] power-on flag cleared only by software
// [R12] legacy mode keeps pin and power-on flags
// [R13] control bits 7:5 read zero
// [R14] change-unlock self-clears after four cycles
// [R15] enable clears only while unlocked
// [R16] levels 1,2: prescaler locked without unlock
// [R17] enable starts, permitted zero stops watchdog
// [R18] prescaler doubles time-out from 16384 cycles
// [R19] safety level follows two fuses
// [R20] counter restarts on restart, disable, reset
// [R21] expiry gives one-cycle reset pulse
// [R22] level 0: prescaler change always allowed
// [R23] writing one leaves flag unchanged
// [R24] oscillator synchronised into system clock
`timescale 1ns/100ps
`default_nettype none
module wdg_top
  import wdg_pkg::*;
#(
  parameter int TIMEOUT_BASE = WDG_TIMEOUT_BASE, // oscillator cycles at 000
  parameter int CNT_W        = 21                // watchdog counter width
) (
  input  wire logic       clk_sys_i,                 // system clock, 40 MHz
  input  wire logic       resetn_i,                  // power-on reset, low
  input  wire logic       wdt_osc_i,                 // watchdog oscillator
  input  wire logic       legacy_compat_fuse_i,      // 1 = programmed
  input  wire logic       watchdog_always_on_fuse_i, // 1 = programmed
  input  wire logic       chip_reset_i,              // any non-power-on reset
  input  wire logic       rst_scan_i,                // cause: scan-chain reset
  input  wire logic       rst_dip_i,                 // cause: supply dip
  input  wire logic       rst_pin_i,                 // cause: reset pin
  input  wire logic       wdt_restart_i,             // restart instruction
  input  wire logic [7:0] reg_addr_i,                // register byte address
  input  wire logic [7:0] reg_wdata_i,               // write data
  input  wire logic       reg_wr_i,                  // write strobe
  input  wire logic       reg_rd_i,                  // read strobe
  output logic      [7:0] reg_rdata_o,               // read data, next cycle
  output logic            wdt_reset_o,               // expiry reset pulse
  output logic            wdt_running_o              // watchdog counting
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // the longest time-out minus one must fit the counter
  if (TIMEOUT_BASE < 2 || CNT_W > 30 ||
      longint'(TIMEOUT_BASE) * 128 - 1 >= (longint'(1) << CNT_W)) begin : g_chk
    $error("wdg_top: TIMEOUT_BASE does not fit CNT_W");
  end

  // last oscillator tick count of the selected period
  function automatic logic [CNT_W-1:0] last_tick(input logic [2:0] ps);
    int n;
    n = (TIMEOUT_BASE << ps) - 1;
    return n[CNT_W-1:0];
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_r; // first stage, read only by rst_n_r
  logic rst_n_r;    // released reset used by the design

  // asserts at once, releases after two edges
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ****************************************************************
  // oscillator synchroniser
  // ****************************************************************
  logic osc_meta_r; // first stage, read only by osc_s_r
  logic osc_s_r;    // synchronised oscillator level
  logic osc_d_r;    // delayed copy for edge detection
  logic osc_tick;   // one cycle per oscillator rising edge

  // level crossing: the oscillator is far slower than clk_sys_i
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_meta_r <= 1'b0;
      osc_s_r    <= 1'b0;
      osc_d_r    <= 1'b0;
    end else begin
      osc_meta_r <= wdt_osc_i; // [R24]
      osc_s_r    <= osc_meta_r;
      osc_d_r    <= osc_s_r;
    end
  end
  assign osc_tick = osc_s_r & ~osc_d_r; // [R24]

  // ****************************************************************
  // safety level
  // ****************************************************************
  wdg_level_type lvl; // decoded from the fuses

  // always-on wins over the compat fuse
  always_comb begin
    if (watchdog_always_on_fuse_i) begin
      lvl = WDG_LVL2; // [R19]
    end else if (legacy_compat_fuse_i) begin
      lvl = WDG_LVL0; // [R19]
    end else begin
      lvl = WDG_LVL1; // [R19]
    end
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic ctl_wr;   // write to watchdog_control
  logic cause_wr; // write to reset_cause_status
  assign ctl_wr   = reg_wr_i && (reg_addr_i == WDG_ADDR_CONTROL);
  assign cause_wr = reg_wr_i && (reg_addr_i == WDG_ADDR_RST_CAUSE);

  // ****************************************************************
  // watchdog_control
  // ****************************************************************
  logic [2:0]          win_r, win_nxt; // unlock window cycles left
  logic                en_r, en_nxt;   // stored enable
  logic [WDG_PS_HI:0]  ps_r, ps_nxt;   // timeout_prescale_select
  logic                unlock_r;       // watchdog_change_unlock
  logic                en_eff;         // enable as seen by the counter
  logic                lvl2;           // level 2 in force
  logic                open_wr;        // write that opens the window
  logic                d_unlock;       // written change-unlock bit
  logic                d_en;           // written enable bit

  assign d_unlock = reg_wdata_i[WDG_BIT_UNLOCK];
  assign d_en     = reg_wdata_i[WDG_BIT_EN];
  assign unlock_r = (win_r != 3'h0); // [R14]
  assign lvl2     = (lvl == WDG_LVL2);
  assign en_eff   = en_r | lvl2; // [R4] [R6]
  // levels 1 and 2 need enable written one beside the unlock bit
  assign open_wr  = ctl_wr && d_unlock && (d_en || lvl == WDG_LVL0); // [R2]

  // next control values
  always_comb begin
    win_nxt = unlock_r ? win_r - 3'h1 : win_r; // [R14]
    en_nxt  = en_r;
    ps_nxt  = ps_r;
    if (chip_reset_i) begin
      // any chip reset returns to the initial state
      win_nxt = 3'h0;
      en_nxt  = 1'b0; // [R1]
      ps_nxt  = WDG_PS_RST;
    end else if (ctl_wr) begin
      if (open_wr) begin
        win_nxt = WDG_UNLOCK_CYCLES; // [R14]
      end
      if (d_en) begin
        en_nxt = 1'b1; // [R1] [R17]
      end else if (unlock_r && !lvl2) begin
        en_nxt = 1'b0; // [R15] [R17]
      end
      // locked levels take a prescaler only in a write inside the window without change-unlock
      case (lvl)
        WDG_LVL0: ps_nxt = reg_wdata_i[WDG_PS_HI:0]; // [R22]
        WDG_LVL1,
        WDG_LVL2: begin
          if (unlock_r && !d_unlock) begin
            ps_nxt = reg_wdata_i[WDG_PS_HI:0]; // [R3] [R5] [R16]
          end
        end
        default: ps_nxt = ps_r;
      endcase
    end
  end

  // control registers
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      win_r <= 3'h0;
      en_r  <= 1'b0;
      ps_r  <= WDG_PS_RST;
    end else begin
      win_r <= win_nxt;
      en_r  <= en_nxt;
      ps_r  <= ps_nxt;
    end
  end

  // ****************************************************************
  // watchdog counter
  // ****************************************************************
  logic [CNT_W-1:0] wcnt_r, wcnt_nxt; // oscillator ticks counted
  logic             exp_r, exp_nxt;   // expiry pulse

  // counts synchronised ticks, held at zero while stopped
  always_comb begin
    wcnt_nxt = wcnt_r;
    exp_nxt  = 1'b0;
    if (!en_eff || wdt_restart_i || chip_reset_i) begin
      wcnt_nxt = '0; // [R20]
    end else if (osc_tick) begin
      if (wcnt_r >= last_tick(ps_r)) begin
        // a shorter period chosen late expires on the next tick
        wcnt_nxt = '0;
        exp_nxt  = 1'b1; // [R18] [R21]
      end else begin
        wcnt_nxt = wcnt_r + CNT_W'(1);
      end
    end
  end

  // counter registers
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wcnt_r <= '0;
      exp_r  <= 1'b0;
    end else begin
      wcnt_r <= wcnt_nxt;
      exp_r  <= exp_nxt;
    end
  end

  assign wdt_reset_o   = exp_r; // [R21]
  assign wdt_running_o = en_eff;

  // ****************************************************************
  // reset_cause_status
  // ****************************************************************
  logic [7:0] cause_r, cause_nxt; // reset-cause flags
  logic [7:0] cause_set;          // flags raised this cycle
  logic [7:0] cause_mask;         // flags that exist in this mode

  // a set in the same cycle as a software clear wins
  always_comb begin
    cause_set               = 8'h00;
    cause_set[WDG_BIT_SCAN] = rst_scan_i; // [R7]
    cause_set[WDG_BIT_WDOG] = exp_r;      // [R8]
    cause_set[WDG_BIT_DIP]  = rst_dip_i;  // [R9]
    cause_set[WDG_BIT_PIN]  = rst_pin_i;  // [R10]
    cause_mask = legacy_compat_fuse_i ? WDG_CAUSE_LEGACY : WDG_CAUSE_FULL; // [R12]
    cause_nxt  = cause_r;
    if (cause_wr) begin
      cause_nxt = cause_r & reg_wdata_i; // [R23] [R11]
    end
    cause_nxt = (cause_nxt | cause_set) & cause_mask;
  end

  // power-on leaves only its own flag
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cause_r <= WDG_CAUSE_RST_VAL; // [R11]
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [7:0] rdata_r, rdata_nxt; // read data, valid one cycle

  // unmapped addresses and idle cycles give zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        WDG_ADDR_RST_CAUSE: rdata_nxt = cause_r;
        WDG_ADDR_CONTROL:   rdata_nxt = {WDG_RSVD_ZERO, unlock_r, en_eff, ps_r}; // [R13]
        default:            rdata_nxt = 8'h00;
      endcase
    end
  end

  // read register
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata_o = rdata_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_r);

  sequence s_open;
    open_wr && !chip_reset_i;
  endsequence
  sequence s_window;
    unlock_r [*4];
  endsequence

  // a chip reset closes the window early, so it ends the attempt
  a_unlock_window: assert property (disable iff (!rst_n_r || chip_reset_i) // [R14]
    s_open |=> s_window)
    else $error("unlock window not four cycles");
  a_unlock_close: assert property (win_r == 3'h1 && !open_wr |=> !unlock_r) // [R14]
    else $error("unlock bit did not self-clear");
  a_level2_on: assert property (lvl2 |-> en_eff && wdt_running_o) // [R4] [R6]
    else $error("level 2 watchdog stopped");
  a_level2_read: assert property (lvl2 && reg_rd_i && reg_addr_i == WDG_ADDR_CONTROL // [R4]
    |=> reg_rdata_o[WDG_BIT_EN])
    else $error("level 2 enable read back as zero");
  a_enable_write: assert property (ctl_wr && d_en && !chip_reset_i |=> en_r) // [R17]
    else $error("enable write ignored");
  a_disable_lock: assert property ( // [R15]
    ctl_wr && !d_en && !unlock_r && en_r && !chip_reset_i |=> en_r)
    else $error("enable cleared without unlock");
  a_disable_ok: assert property ( // [R15] [R17]
    ctl_wr && !d_en && unlock_r && !lvl2 && !chip_reset_i |=> !en_r)
    else $error("permitted disable ignored");
  a_ps_locked: assert property ( // [R16]
    ctl_wr && lvl != WDG_LVL0 && !unlock_r && !chip_reset_i |=> $stable(ps_r))
    else $error("prescaler changed while locked");
  a_ps_window: assert property ( // [R3] [R5]
    ctl_wr && lvl != WDG_LVL0 && unlock_r && !d_unlock && !chip_reset_i
    |=> ps_r == $past(reg_wdata_i[WDG_PS_HI:0]))
    else $error("prescaler write inside window lost");
  a_ps_free: assert property ( // [R22]
    ctl_wr && lvl == WDG_LVL0 && !chip_reset_i |=> ps_r == $past(reg_wdata_i[WDG_PS_HI:0]))
    else $error("level 0 prescaler write lost");
  // expiry lasts one cycle and leaves the watchdog flag behind outside legacy mode
  a_expire_pulse: assert property (exp_r |-> ##1 (!exp_r && // [R21] [R8]
    (cause_r[WDG_BIT_WDOG] || legacy_compat_fuse_i)))
    else $error("expiry pulse wrong");
  a_restart_clear: assert property (wdt_restart_i |=> wcnt_r == '0) // [R20]
    else $error("restart did not clear counter");
  a_stop_clear: assert property (!en_eff |=> wcnt_r == '0) // [R20]
    else $error("stopped counter not cleared");
  a_chip_reset: assert property ( // [R1] [R20]
    chip_reset_i |=> !en_r && !unlock_r && wcnt_r == '0)
    else $error("chip reset left control state");
  // reset-cause flags: a hardware set wins over a software clear
  a_pin_flag: assert property (rst_pin_i |=> cause_r[WDG_BIT_PIN]) // [R10]
    else $error("pin flag not set");
  a_scan_flag: assert property ( // [R7]
    rst_scan_i && !legacy_compat_fuse_i |=> cause_r[WDG_BIT_SCAN])
    else $error("scan-chain flag not set");
  a_dip_flag: assert property ( // [R9]
    rst_dip_i && !legacy_compat_fuse_i |=> cause_r[WDG_BIT_DIP])
    else $error("supply-dip flag not set");
  a_flag_keep: assert property ( // [R23]
    cause_wr && (cause_r & ~reg_wdata_i) == 8'h00
    |=> (cause_r & $past(cause_r)) == $past(cause_r))
    else $error("flag lost on a write of one");
  a_por_kept: assert property ( // [R11]
    cause_r[WDG_BIT_POR] && !(cause_wr && !reg_wdata_i[WDG_BIT_POR])
    |=> cause_r[WDG_BIT_POR])
    else $error("power-on flag lost");
  a_legacy_mask: assert property ( // [R12]
    legacy_compat_fuse_i |=> (cause_r & ~WDG_CAUSE_LEGACY) == 8'h00)
    else $error("legacy flags present");
  a_rsvd_zero: assert property ( // [R13]
    reg_rd_i && ctl_wr == 1'b0 && reg_addr_i == WDG_ADDR_CONTROL
    |=> reg_rdata_o[7:5] == WDG_RSVD_ZERO)
    else $error("reserved bits not zero");

endmodule
`default_nettype wire

// ---- verif/wdg_tb.sv ----
// self-checking testbench for the watchdog control and reset-cause block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import wdg_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic       clk_sys_i = 1'b0; // 40 MHz system clock
  logic       resetn_i  = 1'b0; // power-on reset, low
  logic       osc       = 1'b0; // free-running watchdog oscillator
  logic [1:0] osc_div   = 2'h0; // divider, half period of four clocks
  logic       lc_fuse   = 1'b0; // legacy compatibility fuse
  logic       ao_fuse   = 1'b0; // always-on fuse
  logic       chip_rst  = 1'b0; // non-power-on chip reset
  logic       rs_scan   = 1'b0; // scan-chain reset cause
  logic       rs_dip    = 1'b0; // supply-dip reset cause
  logic       rs_pin    = 1'b0; // reset-pin cause
  logic       restart   = 1'b0; // restart instruction pulse
  logic [7:0] addr      = 8'h00; // register address
  logic [7:0] wdata     = 8'h00; // write data
  logic       wr_s      = 1'b0; // write strobe
  logic       rd_s      = 1'b0; // read strobe
  logic [7:0] rdata;            // read data
  logic       wdt_rst;          // expiry pulse
  logic       running;          // watchdog counting
  int         err_total = 0;    // mismatches seen
  int         checked   = 0;    // comparisons made
  int         fires     = 0;    // expiry pulses seen
  int         n;                // cycles to expiry
  // small base keeps a time-out at a few dozen clocks
  wdg_top #(.TIMEOUT_BASE(4), .CNT_W(21)) DUT (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wdt_osc_i(osc),
    .legacy_compat_fuse_i(lc_fuse), .watchdog_always_on_fuse_i(ao_fuse),
    .chip_reset_i(chip_rst), .rst_scan_i(rs_scan), .rst_dip_i(rs_dip),
    .rst_pin_i(rs_pin), .wdt_restart_i(restart), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .wdt_reset_o(wdt_rst), .wdt_running_o(running));
  // ****************************************************************
  // clock, oscillator and pulse counter
  // ****************************************************************
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // oscillator kept well below clock rate so the sampler sees every edge
  always @(posedge clk_sys_i) begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3) osc <= ~osc;
    if (wdt_rst === 1'b1) fires <= fires + 1;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
  endtask
  // read strobe, then data taken in the following cycle only
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic do_reset(input logic lc, input logic ao);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    lc_fuse <= lc;
    ao_fuse <= ao;
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic causes();
    @(posedge clk_sys_i);
    {rs_scan, rs_dip, rs_pin} <= 3'h7;
    @(posedge clk_sys_i);
    {rs_scan, rs_dip, rs_pin} <= 3'h0;
  endtask
  task automatic kick();
    @(posedge clk_sys_i);
    restart <= 1'b1;
    @(posedge clk_sys_i);
    restart <= 1'b0;
  endtask
  // count clocks to the expiry pulse, then see it drop again
  task automatic fire_time(output int cnt);
    cnt = 0;
    #1;
    while (wdt_rst !== 1'b1 && cnt < 300) begin
      @(posedge clk_sys_i);
      #1 cnt++;
    end
    @(posedge clk_sys_i);
    #1 chk({7'h0, wdt_rst}, 8'h00);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_level1();
    do_reset(1'b0, 1'b0);
    rdc(WDG_ADDR_RST_CAUSE, 8'h01);
    rdc(WDG_ADDR_CONTROL, 8'h00);
    chk({7'h0, running}, 8'h00);
    wr(WDG_ADDR_CONTROL, 8'hE8);
    rdc(WDG_ADDR_CONTROL, 8'h08);
    chk({7'h0, running}, 8'h01);
    wr(WDG_ADDR_CONTROL, 8'h00);
    rdc(WDG_ADDR_CONTROL, 8'h08);
    wr(WDG_ADDR_CONTROL, 8'h0B);
    rdc(WDG_ADDR_CONTROL, 8'h08);
    wr(WDG_ADDR_CONTROL, 8'h18);
    rdc(WDG_ADDR_CONTROL, 8'h18);
    wr(WDG_ADDR_CONTROL, 8'h0D);
    rdc(WDG_ADDR_CONTROL, 8'h0D);
    wr(WDG_ADDR_CONTROL, 8'h18);
    repeat (6) @(posedge clk_sys_i);
    rdc(WDG_ADDR_CONTROL, 8'h0D);
    wr(WDG_ADDR_CONTROL, 8'h0A);
    rdc(WDG_ADDR_CONTROL, 8'h0D);
    wr(WDG_ADDR_CONTROL, 8'h18);
    wr(WDG_ADDR_CONTROL, 8'h00);
    rdc(WDG_ADDR_CONTROL, 8'h10);
    chk({7'h0, running}, 8'h00);
    rdc(8'h08, 8'h00);
  endtask
  task automatic t_flags();
    causes();
    rdc(WDG_ADDR_RST_CAUSE, 8'h17);
    wr(WDG_ADDR_RST_CAUSE, 8'hFF);
    rdc(WDG_ADDR_RST_CAUSE, 8'h17);
    wr(WDG_ADDR_CONTROL, 8'h0F);
    @(posedge clk_sys_i);
    chip_rst <= 1'b1;
    @(posedge clk_sys_i);
    chip_rst <= 1'b0;
    rdc(WDG_ADDR_RST_CAUSE, 8'h17);
    rdc(WDG_ADDR_CONTROL, 8'h00);
    wr(WDG_ADDR_RST_CAUSE, 8'h1E);
    rdc(WDG_ADDR_RST_CAUSE, 8'h16);
    wr(WDG_ADDR_RST_CAUSE, 8'h00);
    rdc(WDG_ADDR_RST_CAUSE, 8'h00);
  endtask
  // expiry window is loose: tick phase and the sampler add a few clocks
  task automatic t_timeout();
    int f0;
    wr(WDG_ADDR_CONTROL, 8'h08);
    kick();
    fire_time(n);
    chk({7'h0, n >= 18 && n <= 44}, 8'h01);
    rdc(WDG_ADDR_RST_CAUSE, 8'h08);
    f0 = fires;
    repeat (8) begin
      kick();
      repeat (14) @(posedge clk_sys_i);
    end
    chk(8'(fires - f0), 8'h00);
    wr(WDG_ADDR_CONTROL, 8'h18);
    wr(WDG_ADDR_CONTROL, 8'h09);
    kick();
    fire_time(n);
    chk({7'h0, n >= 50 && n <= 80}, 8'h01);
    wr(WDG_ADDR_CONTROL, 8'h18);
    wr(WDG_ADDR_CONTROL, 8'h00);
    f0 = fires;
    repeat (150) @(posedge clk_sys_i);
    chk(8'(fires - f0), 8'h00);
  endtask
  task automatic t_level2();
    do_reset(1'b0, 1'b1);
    chk({7'h0, running}, 8'h01);
    rdc(WDG_ADDR_CONTROL, 8'h08);
    wr(WDG_ADDR_CONTROL, 8'h03);
    rdc(WDG_ADDR_CONTROL, 8'h08);
    wr(WDG_ADDR_CONTROL, 8'h18);
    wr(WDG_ADDR_CONTROL, 8'h01);
    rdc(WDG_ADDR_CONTROL, 8'h19);
    wr(WDG_ADDR_CONTROL, 8'h18);
    wr(WDG_ADDR_CONTROL, 8'h00);
    rdc(WDG_ADDR_CONTROL, 8'h18);
    chk({7'h0, running}, 8'h01);
  endtask
  task automatic t_level0();
    do_reset(1'b1, 1'b0);
    rdc(WDG_ADDR_CONTROL, 8'h00);
    wr(WDG_ADDR_CONTROL, 8'h03);
    rdc(WDG_ADDR_CONTROL, 8'h03);
    causes();
    rdc(WDG_ADDR_RST_CAUSE, 8'h03);
  endtask
  // ****************************************************************
  // verdict, main sequence and watchdog
  // ****************************************************************
  task automatic close_out();
    $display("checks made %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_level1();
    t_flags();
    t_timeout();
    t_level2();
    t_level0();
    close_out();
  end
  // whole run needs about 520 clocks; cut a hang well beyond that
  initial begin
    #150000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
